//--- hw/pdvr_consts.svh
`ifndef PDVR_CONSTS_SVH
`define PDVR_CONSTS_SVH

// Register offsets, page 0.
`define PDVR_OFS_RX_CTRL    8'h96
`define PDVR_OFS_RX_STAT    8'h97
`define PDVR_OFS_DRAIN      8'h98
`define PDVR_OFS_OT_CTRL    8'h99
`define PDVR_OFS_TMR_LO     8'hA0
`define PDVR_OFS_TMR_HI     8'hA1
`define PDVR_OFS_PAGE       8'hFF

// Field positions.
`define PDVR_B_THR_OVR      2
`define PDVR_B_THR_SEL_HI   1
`define PDVR_B_THR_SEL_LO   0
`define PDVR_B_RX_PRE       3
`define PDVR_B_RX_CRC       2
`define PDVR_B_RX_EOP       1
`define PDVR_B_RX_SOP       0
`define PDVR_B_VCONN_OFF    1
`define PDVR_B_VBUS_OFF     0
`define PDVR_B_OT_LIVE      4
`define PDVR_B_OT_ON        0
`define PDVR_B_PAGE         0

// Reset values.
`define PDVR_RST_BYTE       8'h00
`define PDVR_RST_WORD       16'h0000

// Timer unit and clock rate.
`define PDVR_MS_UNIT_US     1000
`define PDVR_CLK_KHZ        25000

`endif

//--- hw/pdvr_pkg.sv
package pdvr_pkg;

    // Register access from the serial slave engine.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pdvr_req_t;

    // Receive progress levels from the BMC receiver.
    typedef struct packed {
        logic preamble;
        logic crc_ok;
        logic eop;
        logic sop;
    } pdvr_rx_ev_t;

    // Receive threshold pairs, high level first.
    typedef enum logic [1:0] {
        THR_SNK = 2'h0,
        THR_SRC = 2'h1,
        THR_NEU = 2'h2,
        THR_MIX = 2'h3
    } pdvr_thr_t;

    typedef enum logic [1:0] {
        TMR_IDLE = 2'b01,
        TMR_RUN  = 2'b10
    } pdvr_tmr_state_t;

    typedef struct packed {
        logic [1:0]  thr_sel;
        logic        thr_ovr;
        pdvr_thr_t   thr_eff;
        pdvr_rx_ev_t rx_stat;
        logic        cable_off;
        logic        bus_off;
        logic        vconn_drain;
        logic        vbus_drain;
        logic        ot_on;
        logic [2:0]  ot_sync;
        logic        ot_live;
        logic [7:0]  tmr_lo;
        logic [7:0]  tmr_hi;
        logic        ld;
        logic [15:0] ld_val;
        logic        page;
        logic [7:0]  rdata;
    } pdvr_regs_st_t;

endpackage

//--- hw/pdvr_ms_timer.sv
`include "pdvr_consts.svh"

module pdvr_ms_timer
    import pdvr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 25000,
    parameter int unsigned CNT_W       = 16
)
(
    input  wire logic             clk_sys_in,   // System clock.
    input  wire logic             reset_n_in,   // Async reset, low.
    input  wire logic             load_in,      // Apply value, pulse.
    input  wire logic [CNT_W-1:0] value_in,     // Units of one ms.
    output logic                  expired_out,  // Reached zero, pulse.
    output logic                  running_out   // Counting.
);

    localparam int unsigned PRE_W = $clog2(TICK_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

    typedef struct packed {
        pdvr_tmr_state_t  state;
        logic [CNT_W-1:0] count;
        logic [PRE_W-1:0] pre;
        logic             expired;
        logic             running;
    } pdvr_tmr_st_t;

    pdvr_tmr_st_t st_ff;
    pdvr_tmr_st_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.expired = 1'b0;
        if (load_in)
        begin
            nxt_st.pre = '0;
            nxt_st.count = value_in;
            if (value_in != '0)
            begin
                nxt_st.state = TMR_RUN;
            end
            else
            begin
                nxt_st.state = TMR_IDLE;
            end
        end
        else
        begin
            case (st_ff.state)
                TMR_RUN:
                begin
                    if (st_ff.pre == PRE_LAST)
                    begin
                        nxt_st.pre = '0;
                        if (st_ff.count <= CNT_W'(1))
                        begin
                            nxt_st.count = '0;
                            nxt_st.state = TMR_IDLE;
                            nxt_st.expired = 1'b1;
                        end
                        else
                        begin
                            nxt_st.count = st_ff.count - CNT_W'(1);
                        end
                    end
                    else
                    begin
                        nxt_st.pre = st_ff.pre + PRE_W'(1);
                    end
                end
                default:
                begin
                    nxt_st.state = TMR_IDLE;
                end
            endcase
        end
        nxt_st.running = (nxt_st.state == TMR_RUN);
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            st_ff <= '{state: TMR_IDLE, default: '0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign expired_out = st_ff.expired;
    assign running_out = st_ff.running;

    default clocking tmr_cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);

    tmr_expire_a: assert property (
        st_ff.state == TMR_RUN && st_ff.count == CNT_W'(1)
        && st_ff.pre == PRE_LAST && !load_in
        |=> expired_out && !running_out)
        else $error("Timer did not expire at zero.");

    tmr_zero_off_a: assert property (
        load_in && value_in == '0 |=> !running_out && !expired_out
        ##1 !expired_out)
        else $error("Zero load did not stop the timer.");

    tmr_unit_a: assert property (
        st_ff.state == TMR_RUN && !load_in && st_ff.pre != PRE_LAST
        |=> st_ff.count == $past(st_ff.count) && !expired_out)
        else $error("Count moved inside one unit.");

    tmr_start_a: assert property (
        load_in && value_in != '0 |=> running_out
        && st_ff.count == $past(value_in) && st_ff.pre == '0)
        else $error("Non-zero load did not start the timer.");

    tmr_expire_c: cover property (expired_out);

endmodule

//--- hw/pdvr_regs.sv
// Behaviour
// - Override 0: role picks receive thresholds; override 1: select field picks.
// - Status bit 3 shows preamble received, zero otherwise.
// - Status bit 2 shows packet CRC good.
// - Status bit 1 shows end of packet received.
// - Status bit 0 shows start of packet received.
// - Cable power drains internally only while its off bit is 0.
// - Bus power drains internally only while its off bit is 0.
// - Control bit 4 reads the live over-temperature detector output.
// - Low byte is staged; writing high byte applies the 16-bit value.
// - Timer byte reads return written values, never the live count.
// - Non-zero value starts countdown; reaching zero raises expiry flag.
// - Zero value stops the timer with no expiry flag.
// - One timer unit lasts 1000 microseconds.
// - Page bit 0 selects page 0 or the test page.
`include "pdvr_consts.svh"

module pdvr_regs
    import pdvr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES =
        `PDVR_MS_UNIT_US * `PDVR_CLK_KHZ / 1000,
    parameter int unsigned CNT_W       = 16
)
(
    input  wire logic        clk_sys_in,        // System clock.
    input  wire logic        reset_n_in,        // Async reset, low.
    input  wire pdvr_req_t   reg_req_in,        // Register access.
    input  wire pdvr_rx_ev_t rx_ev_in,          // Receiver progress.
    input  wire logic        power_role_in,     // 1 source, 0 sink.
    input  wire logic        vbus_discharge_in, // Bus drain wanted.
    input  wire logic        vconn_discharge_in,// Cable drain wanted.
    input  wire logic        overtemp_raw_in,   // Detector pin.
    output logic [7:0]       reg_rdata_out,     // Read data.
    output pdvr_thr_t        thr_eff_out,       // Threshold pair.
    output logic             vbus_drain_out,    // Internal bus drain.
    output logic             vconn_drain_out,   // Internal cable drain.
    output logic             overtemp_on_out,   // Detector enable.
    output logic             test_page_out,     // Test page selected.
    output logic             ms_timer_expired_out, // Expiry pulse.
    output logic             ms_timer_running_out  // Timer counting.
);

    pdvr_regs_st_t st_ff;
    pdvr_regs_st_t nxt_st;

    // Page 0 register read; reserved bits and unmapped offsets give zero.
    function automatic logic [7:0] read_byte(input pdvr_regs_st_t s,
                                             input logic [7:0]    a);
        logic [7:0] d;
        d = `PDVR_RST_BYTE;
        if (a == `PDVR_OFS_PAGE)
        begin
            d[`PDVR_B_PAGE] = s.page;
        end
        else if (s.page)
        begin
            d = `PDVR_RST_BYTE;
        end
        else if (a == `PDVR_OFS_RX_CTRL)
        begin
            d[`PDVR_B_THR_OVR] = s.thr_ovr;
            d[`PDVR_B_THR_SEL_HI:`PDVR_B_THR_SEL_LO] = s.thr_sel;
        end
        else if (a == `PDVR_OFS_RX_STAT)
        begin
            d[`PDVR_B_RX_PRE:`PDVR_B_RX_SOP] = s.rx_stat;
        end
        else if (a == `PDVR_OFS_DRAIN)
        begin
            d[`PDVR_B_VCONN_OFF] = s.cable_off;
            d[`PDVR_B_VBUS_OFF] = s.bus_off;
        end
        else if (a == `PDVR_OFS_OT_CTRL)
        begin
            d[`PDVR_B_OT_LIVE] = s.ot_live;
            d[`PDVR_B_OT_ON] = s.ot_on;
        end
        else if (a == `PDVR_OFS_TMR_LO)
        begin
            d = s.tmr_lo;
        end
        else if (a == `PDVR_OFS_TMR_HI)
        begin
            d = s.tmr_hi;
        end
        return d;
    endfunction

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.ld = 1'b0;

        // Three-stage sampling; the level moves once stages two and three agree.
        nxt_st.ot_sync = {st_ff.ot_sync[1:0], overtemp_raw_in};
        if (st_ff.ot_sync[1] == st_ff.ot_sync[2])
        begin
            nxt_st.ot_live = st_ff.ot_sync[2];
        end

        nxt_st.rx_stat = rx_ev_in;

        if (st_ff.thr_ovr)
        begin
            nxt_st.thr_eff = pdvr_thr_t'(st_ff.thr_sel);
        end
        else if (power_role_in)
        begin
            nxt_st.thr_eff = THR_SRC;
        end
        else
        begin
            nxt_st.thr_eff = THR_SNK;
        end

        nxt_st.vconn_drain = vconn_discharge_in && !st_ff.cable_off;
        nxt_st.vbus_drain = vbus_discharge_in && !st_ff.bus_off;

        if (reg_req_in.wr)
        begin
            if (reg_req_in.addr == `PDVR_OFS_PAGE)
            begin
                nxt_st.page = reg_req_in.wdata[`PDVR_B_PAGE];
            end
            else if (st_ff.page)
            begin
                nxt_st.page = st_ff.page;
            end
            else if (reg_req_in.addr == `PDVR_OFS_RX_CTRL)
            begin
                nxt_st.thr_ovr = reg_req_in.wdata[`PDVR_B_THR_OVR];
                nxt_st.thr_sel =
                    reg_req_in.wdata[`PDVR_B_THR_SEL_HI:`PDVR_B_THR_SEL_LO];
            end
            else if (reg_req_in.addr == `PDVR_OFS_DRAIN)
            begin
                nxt_st.cable_off = reg_req_in.wdata[`PDVR_B_VCONN_OFF];
                nxt_st.bus_off = reg_req_in.wdata[`PDVR_B_VBUS_OFF];
            end
            else if (reg_req_in.addr == `PDVR_OFS_OT_CTRL)
            begin
                nxt_st.ot_on = reg_req_in.wdata[`PDVR_B_OT_ON];
            end
            else if (reg_req_in.addr == `PDVR_OFS_TMR_LO)
            begin
                nxt_st.tmr_lo = reg_req_in.wdata;
            end
            else if (reg_req_in.addr == `PDVR_OFS_TMR_HI)
            begin
                // The staged low byte pairs with this write.
                nxt_st.tmr_hi = reg_req_in.wdata;
                nxt_st.ld = 1'b1;
                nxt_st.ld_val = {reg_req_in.wdata, st_ff.tmr_lo};
            end
        end

        if (reg_req_in.rd)
        begin
            nxt_st.rdata = read_byte(st_ff, reg_req_in.addr);
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            st_ff <= '{thr_eff: THR_SNK, ld_val: `PDVR_RST_WORD,
                       default: '0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    pdvr_ms_timer #(
        .TICK_CYCLES (TICK_CYCLES),
        .CNT_W       (CNT_W)
    ) pdvr_ms_timer_i (
        .clk_sys_in  (clk_sys_in),
        .reset_n_in  (reset_n_in),
        .load_in     (st_ff.ld),
        .value_in    (st_ff.ld_val[CNT_W-1:0]),
        .expired_out (ms_timer_expired_out),
        .running_out (ms_timer_running_out)
    );

    assign reg_rdata_out = st_ff.rdata;
    assign thr_eff_out = st_ff.thr_eff;
    assign vbus_drain_out = st_ff.vbus_drain;
    assign vconn_drain_out = st_ff.vconn_drain;
    assign overtemp_on_out = st_ff.ot_on;
    assign test_page_out = st_ff.page;

    default clocking regs_cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);

    wire wr0 = reg_req_in.wr && !st_ff.page;
    wire rd0 = reg_req_in.rd && !st_ff.page;

    thr_role_a: assert property (
        !st_ff.thr_ovr |=>
        thr_eff_out == ($past(power_role_in) ? THR_SRC : THR_SNK))
        else $error("Role did not pick the thresholds.");

    thr_select_a: assert property (
        st_ff.thr_ovr |=> thr_eff_out == pdvr_thr_t'($past(st_ff.thr_sel)))
        else $error("Select field did not pick the thresholds.");

    rx_status_a: assert property (
        rd0 && reg_req_in.addr == `PDVR_OFS_RX_STAT |=>
        reg_rdata_out == {4'h0, $past(st_ff.rx_stat)})
        else $error("Receive status read is wrong.");

    rx_track_a: assert property (
        1'b1 |=> st_ff.rx_stat == $past(rx_ev_in))
        else $error("Receive flags did not follow the receiver.");

    cable_drain_a: assert property (
        vconn_discharge_in && st_ff.cable_off |=> !vconn_drain_out)
        else $error("Cable drain ran while switched off.");

    bus_drain_a: assert property (
        vbus_discharge_in && !st_ff.bus_off |=> vbus_drain_out)
        else $error("Bus drain missing while enabled.");

    ot_live_a: assert property (
        st_ff.ot_sync[2] == st_ff.ot_sync[1] |=>
        st_ff.ot_live == $past(st_ff.ot_sync[2]))
        else $error("Live detector level not taken.");

    tmr_stage_a: assert property (
        wr0 && reg_req_in.addr == `PDVR_OFS_TMR_HI |=> st_ff.ld
        && st_ff.ld_val == {$past(reg_req_in.wdata), $past(st_ff.tmr_lo)})
        else $error("High byte write did not apply the value.");

    tmr_lo_hold_a: assert property (
        wr0 && reg_req_in.addr == `PDVR_OFS_TMR_LO |=> !st_ff.ld)
        else $error("Low byte write applied the timer.");

    tmr_readback_a: assert property (
        rd0 && reg_req_in.addr == `PDVR_OFS_TMR_LO |=>
        reg_rdata_out == $past(st_ff.tmr_lo))
        else $error("Low byte read is not the written value.");

    test_page_a: assert property (
        st_ff.page && reg_req_in.rd && reg_req_in.addr != `PDVR_OFS_PAGE
        |=> reg_rdata_out == 8'h00)
        else $error("Test page read returned data.");

    reserved_a: assert property (
        rd0 && reg_req_in.addr == `PDVR_OFS_OT_CTRL |=>
        reg_rdata_out[7:5] == 3'h0 && reg_rdata_out[3:1] == 3'h0)
        else $error("Reserved bits read non-zero.");

    ctrl_reserved_a: assert property (
        rd0 && reg_req_in.addr == `PDVR_OFS_RX_CTRL |=>
        reg_rdata_out[7:3] == 5'h00)
        else $error("Reserved control bits read non-zero.");

    rx_crc_a: assert property (
        rd0 && reg_req_in.addr == `PDVR_OFS_RX_STAT |=>
        reg_rdata_out[`PDVR_B_RX_CRC] == $past(st_ff.rx_stat.crc_ok))
        else $error("Packet check flag read is wrong.");

    rx_end_a: assert property (
        rd0 && reg_req_in.addr == `PDVR_OFS_RX_STAT |=>
        reg_rdata_out[`PDVR_B_RX_EOP] == $past(st_ff.rx_stat.eop))
        else $error("End of packet flag read is wrong.");

    rx_start_a: assert property (
        rd0 && reg_req_in.addr == `PDVR_OFS_RX_STAT |=>
        reg_rdata_out[`PDVR_B_RX_SOP] == $past(st_ff.rx_stat.sop))
        else $error("Start of packet flag read is wrong.");

    cable_drain_on_a: assert property (
        vconn_discharge_in && !st_ff.cable_off |=> vconn_drain_out)
        else $error("Cable drain missing while enabled.");

    bus_drain_off_a: assert property (
        vbus_discharge_in && st_ff.bus_off |=> !vbus_drain_out)
        else $error("Bus drain ran while switched off.");

    ot_read_a: assert property (
        rd0 && reg_req_in.addr == `PDVR_OFS_OT_CTRL |=>
        reg_rdata_out[`PDVR_B_OT_LIVE] == $past(st_ff.ot_live))
        else $error("Live detector bit read is wrong.");

    tmr_hi_read_a: assert property (
        rd0 && reg_req_in.addr == `PDVR_OFS_TMR_HI |=>
        reg_rdata_out == $past(st_ff.tmr_hi))
        else $error("High byte read is not the written value.");

    // Page 0 registers ignore writes while the test page is selected.
    page_lock_a: assert property (
        st_ff.page && reg_req_in.wr && reg_req_in.addr != `PDVR_OFS_PAGE
        |=> st_ff.thr_ovr == $past(st_ff.thr_ovr) && !st_ff.ld
        && st_ff.tmr_lo == $past(st_ff.tmr_lo))
        else $error("Test page write changed a page 0 register.");

    tmr_load_c: cover property (st_ff.ld && st_ff.ld_val != '0);
    thr_mix_c: cover property (thr_eff_out == THR_MIX);
    page_c: cover property (st_ff.page ##1 !st_ff.page);

endmodule

//--- bench/pdvr_host_model.sv
`include "pdvr_consts.svh"

module pdvr_host_model
    import pdvr_pkg::*;
(
    input  wire logic       clk_sys_in, // System clock.
    input  wire logic [7:0] rdata_in,   // Read data from the bank.
    output pdvr_req_t       req_out     // Register request.
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] rdata_q;

    initial
    begin
        req_out = '0;
        rdata_q = 8'h00;
    end

    // Holds the request through its taking edge, then drops the strobes and
    // inverts address and data so nothing can lean on stale values.
    task automatic xfer(input logic w, input logic r,
                        input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        req_out <= '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge clk_sys_in);
        req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(posedge clk_sys_in);
        #1;
        rdata_q = rdata_in;
    endtask

    // Writes a full timer value, low byte first so the staged byte is fresh.
    task automatic load_timer(input logic [15:0] v);
        xfer(1'b1, 1'b0, `PDVR_OFS_TMR_LO, v[7:0]);
        xfer(1'b1, 1'b0, `PDVR_OFS_TMR_HI, v[15:8]);
    endtask
endmodule

//--- bench/pd_phy_vendor_control_regs_tb_top.sv
`include "pdvr_consts.svh"

module pd_phy_vendor_control_regs_tb_top
    import pdvr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned TICK = 4;

    logic        clk_sys_in;
    logic        reset_n_in;
    pdvr_req_t   req;
    pdvr_rx_ev_t rx_ev;
    logic        role;
    logic        vbus_dis;
    logic        vconn_dis;
    logic        ot_pin;
    logic [7:0]  rdata;
    pdvr_thr_t   thr;
    logic        vbus_dr;
    logic        vconn_dr;
    logic        ot_on;
    logic        tpage;
    logic        expired;
    logic        running;
    logic        seen;
    int          miscompares;
    int          cmp_count;
    logic [7:0]  ofs [7] = '{`PDVR_OFS_RX_CTRL, `PDVR_OFS_RX_STAT,
        `PDVR_OFS_DRAIN, `PDVR_OFS_OT_CTRL, `PDVR_OFS_TMR_LO,
        `PDVR_OFS_TMR_HI, `PDVR_OFS_PAGE};
    logic [3:0]  pats [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hF, 4'h0};

    pdvr_regs #(.TICK_CYCLES(TICK)) pdvr_regs_i (
        .clk_sys_in           (clk_sys_in),
        .reset_n_in           (reset_n_in),
        .reg_req_in           (req),
        .rx_ev_in             (rx_ev),
        .power_role_in        (role),
        .vbus_discharge_in    (vbus_dis),
        .vconn_discharge_in   (vconn_dis),
        .overtemp_raw_in      (ot_pin),
        .reg_rdata_out        (rdata),
        .thr_eff_out          (thr),
        .vbus_drain_out       (vbus_dr),
        .vconn_drain_out      (vconn_dr),
        .overtemp_on_out      (ot_on),
        .test_page_out        (tpage),
        .ms_timer_expired_out (expired),
        .ms_timer_running_out (running)
    );

    pdvr_host_model pdvr_host_model_i (
        .clk_sys_in (clk_sys_in),
        .rdata_in   (rdata),
        .req_out    (req)
    );

    always #20 clk_sys_in = ~clk_sys_in;

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        pdvr_host_model_i.xfer(1'b1, 1'b0, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        pdvr_host_model_i.xfer(1'b0, 1'b1, a, 8'h00);
        chk({8'h00, pdvr_host_model_i.rdata_q}, {8'h00, exp});
    endtask

    // Counts the cycles the timer reports running; expiry must mark the end.
    task automatic run_len(input int exp);
        int n;
        n = 0;
        repeat (10) if (running !== 1'b1) cyc(1);
        while (running === 1'b1 && n < 70000)
        begin
            n++;
            cyc(1);
        end
        chk(16'(n), 16'(exp));
        chk({15'h0, expired}, 16'h0001);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        miscompares++;
        print_verdict();
    end

    initial
    begin
        clk_sys_in = 1'b0;
        reset_n_in = 1'b0;
        rx_ev = '0;
        role = 1'b0;
        vbus_dis = 1'b0;
        vconn_dis = 1'b0;
        ot_pin = 1'b0;
        seen = 1'b0;
        miscompares = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        cyc(1);
        chk({10'h0, thr, vbus_dr, vconn_dr, ot_on, tpage}, 16'h0000);
        foreach (ofs[i]) rd_chk(ofs[i], 8'h00);
        wr(`PDVR_OFS_RX_CTRL, 8'hFF);
        rd_chk(`PDVR_OFS_RX_CTRL, 8'h07);
        wr(`PDVR_OFS_DRAIN, 8'hFF);
        rd_chk(`PDVR_OFS_DRAIN, 8'h03);
        wr(`PDVR_OFS_OT_CTRL, 8'hFF);
        rd_chk(`PDVR_OFS_OT_CTRL, 8'h01);
        chk({15'h0, ot_on}, 16'h0001);
        wr(`PDVR_OFS_RX_STAT, 8'hFF);
        rd_chk(`PDVR_OFS_RX_STAT, 8'h00);
        rd_chk(8'h9A, 8'h00);
        wr(`PDVR_OFS_PAGE, 8'hFE);
        rd_chk(`PDVR_OFS_PAGE, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk_sys_in) role <= (i == 1);
            wr(`PDVR_OFS_RX_CTRL, (i < 2) ? 8'h03 : 8'(i + 2));
            chk({14'h0, thr}, (i < 2) ? 16'(i) : 16'(i - 2));
        end
        foreach (pats[i])
        begin
            @(posedge clk_sys_in) rx_ev <= pats[i];
            rd_chk(`PDVR_OFS_RX_STAT, {4'h0, pats[i]});
        end
        @(posedge clk_sys_in) {vbus_dis, vconn_dis} <= 2'b11;
        for (int i = 3; i >= 0; i--)
        begin
            wr(`PDVR_OFS_DRAIN, 8'(i));
            chk({14'h0, vconn_dr, vbus_dr}, 16'(~i & 3));
        end
        @(posedge clk_sys_in) {vbus_dis, vconn_dis} <= 2'b00;
        cyc(3);
        chk({14'h0, vconn_dr, vbus_dr}, 16'h0000);
        @(posedge clk_sys_in) ot_pin <= 1'b1;
        cyc(6);
        rd_chk(`PDVR_OFS_OT_CTRL, 8'h11);
        @(posedge clk_sys_in) ot_pin <= 1'b0;
        cyc(6);
        rd_chk(`PDVR_OFS_OT_CTRL, 8'h01);
        pdvr_host_model_i.load_timer(16'h0003);
        run_len(3 * TICK);
        pdvr_host_model_i.load_timer(16'h0100);
        run_len(256 * TICK);
        wr(`PDVR_OFS_TMR_LO, 8'h02);
        cyc(4);
        chk({15'h0, running}, 16'h0000);
        wr(`PDVR_OFS_TMR_HI, 8'h00);
        run_len(2 * TICK);
        wr(`PDVR_OFS_TMR_HI, 8'h00);
        run_len(2 * TICK);
        pdvr_host_model_i.load_timer(16'h0105);
        rd_chk(`PDVR_OFS_TMR_LO, 8'h05);
        rd_chk(`PDVR_OFS_TMR_HI, 8'h01);
        chk({15'h0, running}, 16'h0001);
        pdvr_host_model_i.load_timer(16'h0000);
        cyc(3);
        chk({15'h0, running}, 16'h0000);
        repeat (1100)
        begin
            cyc(1);
            seen = seen | (expired !== 1'b0);
        end
        chk({15'h0, seen}, 16'h0000);
        wr(`PDVR_OFS_PAGE, 8'h01);
        chk({15'h0, tpage}, 16'h0001);
        rd_chk(`PDVR_OFS_RX_CTRL, 8'h00);
        wr(`PDVR_OFS_RX_CTRL, 8'h00);
        rd_chk(`PDVR_OFS_PAGE, 8'h01);
        wr(`PDVR_OFS_PAGE, 8'h00);
        chk({15'h0, tpage}, 16'h0000);
        rd_chk(`PDVR_OFS_RX_CTRL, 8'h07);
        print_verdict();
    end
endmodule
